/* File: common/mgu_pkg.sv */
package mgu_pkg;
  // core access and apb address widths
  localparam int MGU_PHYS_W = 20;
  localparam int MGU_PC_W = 16;
  localparam int MGU_PADDR_W = 16;
  // register indices as printed; byte address is four times the index
  localparam logic [11:0] MGU_IDX_PROT_MODE = 12'h440;
  localparam logic [11:0] MGU_IDX_STACK_CTRL = 12'h444;
  localparam logic [11:0] MGU_IDX_STACK_LOW = 12'h445;
  localparam logic [11:0] MGU_IDX_STACK_HIGH = 12'h446;
  localparam logic [11:0] MGU_IDX_SEG_CMP = 12'h448;
  localparam logic [11:0] MGU_IDX_GUARD_LO = 12'h460;
  localparam logic [11:0] MGU_IDX_GUARD_HI = 12'h461;
  localparam logic [11:0] MGU_IDX_IRQ_STAT = 12'h470;
  localparam logic [11:0] MGU_IDX_IRQ_MASK = 12'h471;
  // field positions
  localparam int MGU_BIT_BOTH_MODES = 0;
  localparam int MGU_BIT_STACK_EN = 0;
  localparam int MGU_SEG_MODE_LSB = 0;
  localparam int MGU_BIT_IRQ_STACK = 0;
  localparam int MGU_BIT_IRQ_GUARD = 1;
  localparam int MGU_IRQ_W = 2;
  // fixed low byte of the lower stack bound
  localparam logic [7:0] MGU_STACK_LOW_LSB = 8'h10;
  // reset values
  localparam logic [7:0] MGU_RST_BYTE = 8'h00;
  localparam logic [MGU_IRQ_W-1:0] MGU_RST_IRQ = 2'h0;
  // translation compare modes
  typedef enum logic [1:0] {
    MGU_SEG_OFF = 2'h0,
    MGU_SEG_6 = 2'h1,
    MGU_SEG_5 = 2'h2,
    MGU_SEG_4 = 2'h3
  } mgu_seg_mode_e;
  // one memory access offered by the core
  typedef struct packed {
    logic valid;
    logic write;
    logic stack;
    logic user_mode;
    logic [MGU_PHYS_W-1:0] addr;
  } mgu_access_s;
  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [MGU_PADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } mgu_apb_req_s;
endpackage

/* File: rtl/mgu_guard.sv */
`timescale 1ns/1ps
module mgu_guard #(
  parameter logic [7:0] STACK_HIGH_LSB = 8'hF0 // low byte of upper stack bound
) (
  input wire logic mclk_i, // 50 MHz processor clock
  input wire logic reset_i, // synchronous, active high
  input wire mgu_pkg::mgu_apb_req_s apb_i, // apb request group
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error on unmapped address
  input wire mgu_pkg::mgu_access_s acc_i, // core memory access
  input wire logic [mgu_pkg::MGU_PC_W-1:0] pc_i, // core program counter
  output logic wr_block_o, // suppress the offered write
  output logic guard_viol_o, // write protection violation pulse
  output logic stack_viol_o, // stack limit violation pulse
  output logic data_xlate_o, // select data-type translation
  output logic irq_o // level interrupt
);
  import mgu_pkg::*;

  // software registers
  logic prot_mode_reg; // both-modes bit
  logic stack_en_reg; // stack check enable
  logic [7:0] stack_low_reg; // lower bound high byte
  logic [7:0] stack_high_reg; // upper bound high byte
  logic [7:0] seg_cmp_reg; // compare value and mode
  logic [7:0] guard_lo_reg; // ranges 0 to 7
  logic [7:0] guard_hi_reg; // ranges 8 to 15
  logic [MGU_IRQ_W-1:0] irq_stat_reg; // sticky events
  logic [MGU_IRQ_W-1:0] irq_mask_reg; // interrupt enables
  // output flops
  logic [31:0] prdata_reg; // read data
  logic pready_reg; // ready in access phase
  logic pslverr_reg; // error in access phase
  logic wr_block_reg; // write suppress
  logic stack_viol_reg; // stack violation
  logic xlate_reg; // translation select
  logic irq_reg; // interrupt level
  // combinational terms
  logic [11:0] idx; // register index from byte address
  logic addr_ok; // word aligned and mapped
  logic [31:0] rd_mux; // read value
  logic setup_ph; // apb setup cycle
  logic wr_go; // write takes effect
  logic rd_go; // read completes
  logic [15:0] guard_bits; // all range enables
  logic guard_applies; // mode allows protection
  logic guard_hit; // write hits enabled range
  logic [15:0] stk_addr; // stack address
  logic [15:0] low_bound; // full lower bound
  logic [15:0] high_bound; // full upper bound
  logic stack_hit; // out of range stack access
  logic xlate_next; // translation compare result
  logic [MGU_IRQ_W-1:0] irq_events; // events this cycle
  logic [MGU_IRQ_W-1:0] stat_next; // next status

  assign idx = apb_i.paddr[13:2];
  assign setup_ph = apb_i.psel && !apb_i.penable;
  assign wr_go = apb_i.psel && apb_i.penable && pready_reg && apb_i.pwrite && !pslverr_reg;
  assign rd_go = apb_i.psel && apb_i.penable && pready_reg && !apb_i.pwrite;

  // address decode and read value, upper bits read as zero
  always_comb begin
    addr_ok = (apb_i.paddr[1:0] == 2'h0) && (apb_i.paddr[15:14] == 2'h0);
    rd_mux = 32'h0000_0000;
    case (idx)
      MGU_IDX_PROT_MODE: rd_mux[MGU_BIT_BOTH_MODES] = prot_mode_reg;
      MGU_IDX_STACK_CTRL: rd_mux[MGU_BIT_STACK_EN] = stack_en_reg;
      MGU_IDX_STACK_LOW: rd_mux[7:0] = stack_low_reg;
      MGU_IDX_STACK_HIGH: rd_mux[7:0] = stack_high_reg;
      MGU_IDX_SEG_CMP: rd_mux[7:0] = seg_cmp_reg;
      MGU_IDX_GUARD_LO: rd_mux[7:0] = guard_lo_reg;
      MGU_IDX_GUARD_HI: rd_mux[7:0] = guard_hi_reg;
      MGU_IDX_IRQ_STAT: rd_mux[MGU_IRQ_W-1:0] = irq_stat_reg;
      MGU_IDX_IRQ_MASK: rd_mux[MGU_IRQ_W-1:0] = irq_mask_reg;
      default: addr_ok = 1'b0; // unmapped
    endcase
  end

  // apb answer prepared in setup, presented in access phase
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (setup_ph) begin
      pready_reg <= 1'b1;
      pslverr_reg <= !addr_ok;
      prdata_reg <= addr_ok ? rd_mux : 32'h0000_0000;
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // control registers, only bit 0 is stored
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      prot_mode_reg <= MGU_RST_BYTE[0];
      stack_en_reg <= MGU_RST_BYTE[0];
    end else if (wr_go) begin
      if (idx == MGU_IDX_PROT_MODE) begin
        prot_mode_reg <= apb_i.pwdata[MGU_BIT_BOTH_MODES];
      end
      if (idx == MGU_IDX_STACK_CTRL) begin
        stack_en_reg <= apb_i.pwdata[MGU_BIT_STACK_EN];
      end
    end
  end

  // byte wide registers and the interrupt mask
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      stack_low_reg <= MGU_RST_BYTE;
      stack_high_reg <= MGU_RST_BYTE;
      seg_cmp_reg <= MGU_RST_BYTE;
      guard_lo_reg <= MGU_RST_BYTE;
      guard_hi_reg <= MGU_RST_BYTE;
      irq_mask_reg <= MGU_RST_IRQ;
    end else if (wr_go) begin
      case (idx)
        MGU_IDX_STACK_LOW: stack_low_reg <= apb_i.pwdata[7:0];
        MGU_IDX_STACK_HIGH: stack_high_reg <= apb_i.pwdata[7:0];
        MGU_IDX_SEG_CMP: seg_cmp_reg <= apb_i.pwdata[7:0];
        MGU_IDX_GUARD_LO: guard_lo_reg <= apb_i.pwdata[7:0];
        MGU_IDX_GUARD_HI: guard_hi_reg <= apb_i.pwdata[7:0];
        MGU_IDX_IRQ_MASK: irq_mask_reg <= apb_i.pwdata[MGU_IRQ_W-1:0];
        default: ; // others held elsewhere or unmapped
      endcase
    end
  end

  // write protection check
  always_comb begin
    guard_bits = {guard_hi_reg, guard_lo_reg};
    guard_applies = prot_mode_reg || acc_i.user_mode;
    guard_hit = acc_i.valid && acc_i.write && guard_applies &&
                guard_bits[acc_i.addr[MGU_PHYS_W-1:16]];
  end

  // stack bound check
  always_comb begin
    stk_addr = acc_i.addr[15:0];
    low_bound = {stack_low_reg, MGU_STACK_LOW_LSB};
    high_bound = {stack_high_reg, STACK_HIGH_LSB};
    stack_hit = stack_en_reg && acc_i.valid && acc_i.stack &&
                ((stk_addr < low_bound) || (stk_addr > high_bound));
  end

  // program counter compare for data-type translation
  always_comb begin
    case (mgu_seg_mode_e'(seg_cmp_reg[MGU_SEG_MODE_LSB +: 2]))
      MGU_SEG_OFF: xlate_next = 1'b0;
      MGU_SEG_6: xlate_next = (pc_i[15:10] == seg_cmp_reg[7:2]);
      MGU_SEG_5: xlate_next = (pc_i[15:11] == seg_cmp_reg[7:3]);
      MGU_SEG_4: xlate_next = (pc_i[15:12] == seg_cmp_reg[7:4]);
      default: xlate_next = 1'b0;
    endcase
  end

  // check results, one cycle after the access
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wr_block_reg <= 1'b0;
      stack_viol_reg <= 1'b0;
      xlate_reg <= 1'b0;
    end else begin
      wr_block_reg <= guard_hit;
      stack_viol_reg <= stack_hit;
      xlate_reg <= xlate_next;
    end
  end

  // sticky status, set wins over read clear
  always_comb begin
    irq_events = '0;
    irq_events[MGU_BIT_IRQ_STACK] = stack_hit;
    irq_events[MGU_BIT_IRQ_GUARD] = guard_hit;
    stat_next = irq_stat_reg;
    // clear only the bits the reader was shown, so an event caught at the setup edge survives
    if (rd_go && !pslverr_reg && idx == MGU_IDX_IRQ_STAT) begin
      stat_next = irq_stat_reg & ~prdata_reg[MGU_IRQ_W-1:0];
    end
    stat_next = stat_next | irq_events;
  end

  // status register and interrupt level
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_stat_reg <= MGU_RST_IRQ;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= stat_next;
      irq_reg <= |(stat_next & irq_mask_reg);
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign wr_block_o = wr_block_reg;
  assign guard_viol_o = wr_block_reg;
  assign stack_viol_o = stack_viol_reg;
  assign data_xlate_o = xlate_reg;
  assign irq_o = irq_reg;

  // checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  // write guard checks
  // user-only mode leaves system writes alone
  a_user_mode_only: assert property (
    acc_i.valid && acc_i.write && !acc_i.user_mode && !prot_mode_reg |=> !wr_block_o)
    else $error("system write blocked in user-only mode");
  // both-modes setting guards system writes too
  a_both_modes_sys: assert property (
    acc_i.valid && acc_i.write && !acc_i.user_mode && prot_mode_reg && guard_bits[acc_i.addr[19:16]] |=> wr_block_o)
    else $error("system write not blocked in both-modes setting");
  // enabled lower range blocks a user write
  a_low_range_block: assert property (
    acc_i.valid && acc_i.write && acc_i.user_mode && !acc_i.addr[19] && guard_lo_reg[acc_i.addr[18:16]]
    |=> wr_block_o && guard_viol_o) else $error("lower range write not blocked");
  // disabled lower range lets a user write pass
  a_low_range_clear: assert property (
    acc_i.valid && acc_i.write && acc_i.user_mode && !acc_i.addr[19] && !guard_lo_reg[acc_i.addr[18:16]]
    |=> !wr_block_o) else $error("lower range write blocked while disabled");
  // enabled upper range blocks a write where guarding applies
  a_high_range_block: assert property (
    acc_i.valid && acc_i.write && (acc_i.user_mode || prot_mode_reg) && acc_i.addr[19] && guard_hi_reg[acc_i.addr[18:16]]
    |=> wr_block_o) else $error("upper range write not blocked");
  // disabled upper range lets a user write pass
  a_high_range_clear: assert property (
    acc_i.valid && acc_i.write && acc_i.user_mode && acc_i.addr[19] && !guard_hi_reg[acc_i.addr[18:16]]
    |=> !wr_block_o) else $error("upper range write blocked while disabled");
  // no block without an offered write
  a_no_false_block: assert property (
    !(acc_i.valid && acc_i.write) |=> !wr_block_o)
    else $error("block without a write");
  // a blocked write pulses the violation and sets its status bit
  a_guard_status: assert property (
    guard_hit |=> guard_viol_o && irq_stat_reg[MGU_BIT_IRQ_GUARD])
    else $error("guard violation not recorded");

  // stack checks
  // below the lower bound, with the fixed low byte
  a_stack_below: assert property (
    stack_en_reg && acc_i.valid && acc_i.stack && acc_i.addr[15:0] < {stack_low_reg, MGU_STACK_LOW_LSB}
    |=> stack_viol_o && irq_stat_reg[MGU_BIT_IRQ_STACK]) else $error("low stack violation missed");
  // above the upper bound, with the parameter low byte
  a_stack_above: assert property (
    stack_en_reg && acc_i.valid && acc_i.stack && acc_i.addr[15:0] > {stack_high_reg, STACK_HIGH_LSB}
    |=> stack_viol_o && irq_stat_reg[MGU_BIT_IRQ_STACK]) else $error("high stack violation missed");
  // inside both bounds nothing is flagged
  a_stack_inside: assert property (
    acc_i.valid && acc_i.stack && acc_i.addr[15:0] >= {stack_low_reg, MGU_STACK_LOW_LSB}
    && acc_i.addr[15:0] <= {stack_high_reg, STACK_HIGH_LSB} |=> !stack_viol_o) else $error("in-range stack flagged");
  // nothing while checking is off
  a_stack_off: assert property (
    !stack_en_reg |=> !stack_viol_o)
    else $error("stack violation while disabled");
  // only stack accesses are checked
  a_stack_plain: assert property (
    !(acc_i.valid && acc_i.stack) |=> !stack_viol_o)
    else $error("stack violation without a stack access");

  // translation checks
  // mode 00 never selects translation
  a_xlate_off: assert property (
    seg_cmp_reg[1:0] == 2'h0 |=> !data_xlate_o)
    else $error("translation forced in mode 00");
  // mode 01 follows the six-bit compare
  a_xlate_six: assert property (
    seg_cmp_reg[1:0] == 2'h1 |=> data_xlate_o == ($past(pc_i[15:10]) == $past(seg_cmp_reg[7:2])))
    else $error("mode 01 compare wrong");
  // mode 10 match selects translation
  a_xlate_five: assert property (
    seg_cmp_reg[1:0] == 2'h2 && pc_i[15:11] == seg_cmp_reg[7:3] |=> data_xlate_o)
    else $error("mode 10 compare missed");
  // mode 10 mismatch leaves translation off
  a_xlate_five_miss: assert property (
    seg_cmp_reg[1:0] == 2'h2 && pc_i[15:11] != seg_cmp_reg[7:3] |=> !data_xlate_o)
    else $error("mode 10 false match");
  // mode 11 mismatch leaves translation off
  a_xlate_four: assert property (
    seg_cmp_reg[1:0] == 2'h3 && pc_i[15:12] != seg_cmp_reg[7:4] |=> !data_xlate_o)
    else $error("mode 11 false match");
  // mode 11 match selects translation
  a_xlate_four_hit: assert property (
    seg_cmp_reg[1:0] == 2'h3 && pc_i[15:12] == seg_cmp_reg[7:4] |=> data_xlate_o)
    else $error("mode 11 compare missed");

  // bus and status checks
  // ready stands for exactly one access cycle
  a_apb_ready: assert property (
    setup_ph |=> pready_o ##1 !pready_o)
    else $error("apb ready not one access cycle");
  // unmapped or misaligned address answers with an error and zero data
  a_apb_error: assert property (
    setup_ph && !addr_ok |=> pready_o && pslverr_o && prdata_o == 32'h0000_0000)
    else $error("unmapped access not refused");
  // read data is the register value seen at setup
  a_apb_readback: assert property (
    setup_ph && !apb_i.pwrite && addr_ok |=> prdata_o == $past(rd_mux))
    else $error("read data wrong");
  // a refused write leaves the range, stack bound and compare registers alone
  a_bad_write_ignored: assert property (
    apb_i.psel && apb_i.penable && pslverr_o && apb_i.pwrite
    |=> $stable({guard_lo_reg, guard_hi_reg, stack_low_reg, stack_high_reg, seg_cmp_reg})) else $error("refused write landed");
  // a status read clears what it showed, new events stay set
  a_stat_read_clear: assert property (
    rd_go && !pslverr_reg && idx == MGU_IDX_IRQ_STAT |=> irq_stat_reg ==
    (($past(irq_stat_reg) & ~$past(prdata_reg[MGU_IRQ_W-1:0])) | $past(irq_events))) else $error("status clear wrong");
  // status stays set until a read
  a_stat_sticky: assert property (
    irq_stat_reg[MGU_BIT_IRQ_STACK] && !rd_go |=> irq_stat_reg[MGU_BIT_IRQ_STACK])
    else $error("stack status lost");
  // interrupt level follows unmasked status
  a_irq_level: assert property (
    1'b1 |=> irq_o == |(irq_stat_reg & $past(irq_mask_reg)))
    else $error("interrupt level wrong");

  // main scenarios
  c_write_blocked: cover property (guard_hit ##1 wr_block_o);
  c_stack_irq: cover property (stack_hit ##1 irq_o);
  c_xlate: cover property (data_xlate_o);
  c_status_read: cover property (rd_go && idx == MGU_IDX_IRQ_STAT && irq_stat_reg != 2'h0);
  c_bus_error: cover property (setup_ph ##1 pslverr_o);
endmodule

/* File: bench/mgu_core_model.sv */
`timescale 1ns/1ps
// behavioural core: offers accesses and program counter values
module mgu_core_model
  import mgu_pkg::*;
(
  input wire logic mclk_i, // processor clock
  output mgu_pkg::mgu_access_s acc_o, // offered access
  output logic [mgu_pkg::MGU_PC_W-1:0] pc_o // program counter
);
  // idle at time zero
  initial begin
    acc_o = '0;
    pc_o = 16'h0000;
  end
  // one access for one cycle; released fields show the inverse, not the old value
  task automatic offer(input logic wr, input logic stk, input logic usr, input logic [MGU_PHYS_W-1:0] a);
    @(posedge mclk_i);
    acc_o <= '{valid: 1'b1, write: wr, stack: stk, user_mode: usr, addr: a};
    @(posedge mclk_i);
    acc_o <= '{valid: 1'b0, write: ~wr, stack: ~stk, user_mode: ~usr, addr: ~a};
  endtask
  // new program counter, held until the next call
  task automatic set_pc(input logic [MGU_PC_W-1:0] p);
    @(posedge mclk_i);
    pc_o <= p;
  endtask
endmodule

/* File: bench/memory_guard_unit_bench.sv */
`timescale 1ns/1ps
module memory_guard_unit_bench;
  import mgu_pkg::*;
  // kind 0 guard, 1 stack, 2 translation; a/b/c are register values
  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] a;
    logic [7:0] b;
    logic c;
    logic u;
    logic [19:0] addr;
    logic e;
  } mgu_row_s;
  logic mclk_i, reset_i, pready, pslverr, err;
  logic wr_block, guard_viol, stack_viol, xlate, irq;
  logic [31:0] prdata, rd;
  mgu_apb_req_s apb;
  mgu_access_s acc;
  logic [15:0] pc;
  int errors, compares;
  mgu_row_s rows[20] = '{
    '{2'h0, 8'h08, 8'h00, 1'b0, 1'b1, 20'h31234, 1'b1}, '{2'h0, 8'h08, 8'h00, 1'b0, 1'b0, 20'h31234, 1'b0},
    '{2'h0, 8'h08, 8'h00, 1'b1, 1'b0, 20'h31234, 1'b1}, '{2'h0, 8'h01, 8'h00, 1'b0, 1'b1, 20'h0FFFF, 1'b1},
    '{2'h0, 8'h01, 8'h00, 1'b0, 1'b1, 20'h10000, 1'b0}, '{2'h0, 8'h00, 8'h80, 1'b0, 1'b1, 20'hFFFFF, 1'b1},
    '{2'h0, 8'h00, 8'h01, 1'b0, 1'b1, 20'h80000, 1'b1}, '{2'h0, 8'h00, 8'h01, 1'b0, 1'b1, 20'h90000, 1'b0},
    '{2'h1, 8'h20, 8'h30, 1'b1, 1'b0, 20'h0200F, 1'b1}, '{2'h1, 8'h20, 8'h30, 1'b1, 1'b0, 20'h02010, 1'b0},
    '{2'h1, 8'h20, 8'h30, 1'b1, 1'b0, 20'h030F0, 1'b0}, '{2'h1, 8'h20, 8'h30, 1'b1, 1'b0, 20'h030F1, 1'b1},
    '{2'h1, 8'h20, 8'h30, 1'b0, 1'b0, 20'h0200F, 1'b0}, '{2'h2, 8'hFC, 8'h00, 1'b0, 1'b0, 20'h0FC00, 1'b0},
    '{2'h2, 8'hA5, 8'h00, 1'b0, 1'b0, 20'h0A400, 1'b1}, '{2'h2, 8'hA5, 8'h00, 1'b0, 1'b0, 20'h0A000, 1'b0},
    '{2'h2, 8'hAA, 8'h00, 1'b0, 1'b0, 20'h0A800, 1'b1}, '{2'h2, 8'hAA, 8'h00, 1'b0, 1'b0, 20'h0B000, 1'b0},
    '{2'h2, 8'hB7, 8'h00, 1'b0, 1'b0, 20'h0BFFF, 1'b1}, '{2'h2, 8'hB7, 8'h00, 1'b0, 1'b0, 20'h0C000, 1'b0}};
  mgu_guard dut (.mclk_i(mclk_i), .reset_i(reset_i), .apb_i(apb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .acc_i(acc), .pc_i(pc), .wr_block_o(wr_block), .guard_viol_o(guard_viol),
    .stack_viol_o(stack_viol), .data_xlate_o(xlate), .irq_o(irq));
  mgu_core_model core (.mclk_i(mclk_i), .acc_o(acc), .pc_o(pc));
  // 50 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer: setup, then access held until pready
  task automatic apb_io(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                        output logic [31:0] rdo, output logic erro);
    int n;
    @(posedge mclk_i);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'h0, idx, 2'h0}, pwdata: wd};
    @(posedge mclk_i);
    apb.penable <= 1'b1;
    n = 0;
    #1;
    // ready is looked at 1 ns after the edge: it is the value the next edge samples
    while (pready !== 1'b1 && n < 16) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (n >= 16) errors++;
    rdo = prdata;
    erro = pslverr;
    @(posedge mclk_i);
    apb <= '0;
  endtask
  task automatic wreg(input logic [11:0] idx, input logic [31:0] d);
    apb_io(1'b1, idx, d, rd, err);
  endtask
  task automatic rreg(input logic [11:0] idx, input logic [31:0] exp);
    apb_io(1'b0, idx, 32'h0, rd, err);
    check(rd, exp);
  endtask
  // verdict and end of run
  task automatic complete_run();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #200000;
    errors++;
    complete_run();
  end
  initial begin
    errors = 0;
    compares = 0;
    reset_i = 1'b1;
    apb = '0;
    repeat (16) @(posedge mclk_i);
    reset_i <= 1'b0;
    #1 check({wr_block, guard_viol, stack_viol, xlate, irq, pready}, 32'h0);
    rreg(MGU_IDX_GUARD_LO, 32'h0);
    rreg(MGU_IDX_STACK_CTRL, 32'h0);
    $display("reset test done");
    // table of ordinary cases
    foreach (rows[i]) begin
      case (rows[i].kind)
        2'h0: begin
          wreg(MGU_IDX_GUARD_LO, rows[i].a);
          wreg(MGU_IDX_GUARD_HI, rows[i].b);
          wreg(MGU_IDX_PROT_MODE, rows[i].c);
          core.offer(1'b1, 1'b0, rows[i].u, rows[i].addr);
          #1 check({wr_block, guard_viol}, {2{rows[i].e}});
        end
        2'h1: begin
          wreg(MGU_IDX_STACK_LOW, rows[i].a);
          wreg(MGU_IDX_STACK_HIGH, rows[i].b);
          wreg(MGU_IDX_STACK_CTRL, rows[i].c);
          core.offer(1'b0, 1'b1, 1'b0, rows[i].addr);
          #1 check(stack_viol, rows[i].e);
        end
        default: begin
          wreg(MGU_IDX_SEG_CMP, rows[i].a);
          core.set_pc(rows[i].addr[15:0]);
          @(posedge mclk_i);
          #1 check(xlate, rows[i].e);
        end
      endcase
    end
    $display("table test done");
    // mode bit readback, unmapped index, read of a guarded range
    wreg(MGU_IDX_PROT_MODE, 32'h1);
    rreg(MGU_IDX_PROT_MODE, 32'h1);
    apb_io(1'b0, 12'h450, 32'h0, rd, err);
    check(err, 1'b1);
    check(rd, 32'h0);
    wreg(MGU_IDX_GUARD_LO, 32'hFF);
    core.offer(1'b0, 1'b0, 1'b1, 20'h10000);
    #1 check(wr_block, 1'b0);
    $display("awkward test done");
    // interrupt raised, cleared by read, masked
    apb_io(1'b0, MGU_IDX_IRQ_STAT, 32'h0, rd, err);
    wreg(MGU_IDX_IRQ_MASK, 32'h1);
    wreg(MGU_IDX_STACK_CTRL, 32'h1);
    core.offer(1'b0, 1'b1, 1'b0, 20'h00000);
    #1 check({stack_viol, irq}, 32'h3);
    rreg(MGU_IDX_IRQ_STAT, 32'h1);
    @(posedge mclk_i);
    #1 check(irq, 1'b0);
    wreg(MGU_IDX_IRQ_MASK, 32'h2);
    core.offer(1'b0, 1'b1, 1'b0, 20'h00000);
    #1 check(irq, 1'b0);
    core.offer(1'b1, 1'b0, 1'b1, 20'h10000);
    #1 check(irq, 1'b1);
    rreg(MGU_IDX_IRQ_STAT, 32'h3);
    $display("interrupt test done");
    // second reset in mid-run
    @(posedge mclk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    #1 check({wr_block, guard_viol, stack_viol, xlate, irq, pready}, 32'h0);
    rreg(MGU_IDX_GUARD_LO, 32'h0);
    rreg(MGU_IDX_IRQ_STAT, 32'h0);
    $display("second reset test done");
    complete_run();
  end
endmodule
